/* design/exec_state_mask.sv */
// Operation
// - state bit 24, bits 31:27,23:16,9:0 zero
// - bits 26:25,15:10 shared resume/cond block
// - exec state reads return zero, writes ignored
// - interrupted transfer records next register 15:12
// - resume transfer from recorded register
// - resume state keeps 26:25,11:10 zero
// - no suspend possible: restart from first register
// - cond block covers up to four instructions
// - inside cond block transfers only restart
// - only compact instruction set state supported
// - state bit changes only from listed sources
// - issue with state bit zero faults
// - masks via special access and change instr
// - interrupt mask blocks configurable priority per bank
// - mask bit 0 only, boost to zero
// - nonsecure mask boost 0x0 or 0x80 by split
// - boost masks equal or lower priorities
// - fault mask also blocks some fixed priorities
// - fault bit 0, boost to minus one; nonsecure without routing 0x0 or 0x80 by split
// - routing set: secure -3, nonsecure -1
module exec_state_mask
  import exec_mask_pkg::*;
#(
  parameter bit SECURE_EXT = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire sreg_req_s sreg_i,
  input wire mask_chg_req_s mask_chg_i,
  input wire tbit_upd_s tbit_i,
  input wire xfer_req_s xfer_i,
  input wire cb_req_s cb_i,
  input wire pend_req_s pend_i,
  input wire logic instr_issue_i,
  input wire logic priority_split_i,
  input wire logic fault_routing_i,
  output logic [31:0] sreg_rdata_o,
  output logic [31:0] exec_state_o,
  output logic resume_valid_o,
  output logic [3:0] resume_reg_o,
  output logic xfer_restart_o,
  output logic cb_active_o,
  output logic state_fault_o,
  output prio_t exec_prio_o,
  output logic pend_blocked_o
);

  function automatic logic [7:0] cb_bits(input logic [31:0] w);
    cb_bits = {w[CB_HI_MSB:CB_HI_LSB], w[CB_LO_MSB:CB_LO_LSB]};
  endfunction

  function automatic logic cb_live(input logic [31:0] w);
    cb_live = (w[CB_LO_MSB:CB_LO_LSB] != TWO_ZERO) ||
              (w[LOW_MSB:LOW_LSB] != TWO_ZERO);
  endfunction

  function automatic prio_t lower(input prio_t a, input prio_t b);
    lower = (b < a) ? b : a;
  endfunction

  logic [31:0] exec_q;
  logic [31:0] next_exec;
  logic restart_q;
  logic next_restart;
  logic fault_q;
  logic next_fault;
  logic imask_s, imask_ns, fblock_s, fblock_ns;
  logic next_imask_s, next_imask_ns, next_fblock_s, next_fblock_ns;
  logic [31:0] rdata_q;
  logic [31:0] next_rdata;
  prio_t prio_q;
  prio_t next_prio;
  logic blocked_q;
  logic next_blocked;
  logic [7:0] cb_next;
  logic bank_s;

  // exec word; later assignments win, exception return last
  always_comb begin
    next_exec = exec_q;
    next_restart = 1'b0;
    cb_next = cb_bits(exec_q);
    if (cb_i.start) begin
      cb_next = cb_i.state;
    end else if (cb_i.step && cb_live(exec_q)) begin
      // base cond kept, mask shifts; zero in bits 2:0 ends the block
      if (cb_next[CB_END_MSB:0] == THREE_ZERO) begin
        cb_next = CB_IDLE;
      end else begin
        cb_next = {cb_next[CB_BASE_MSB:CB_BASE_LSB],
                   cb_next[CB_TAIL_MSB - 1:0], 1'b0};
      end
    end
    if (cb_i.start || cb_i.step) begin
      next_exec[CB_HI_MSB:CB_HI_LSB] = cb_next[7:2];
      next_exec[CB_LO_MSB:CB_LO_LSB] = cb_next[1:0];
    end
    if (xfer_i.intr) begin
      if (xfer_i.can_suspend && !cb_live(exec_q)) begin
        next_exec[RES_MSB:RES_LSB] = xfer_i.next_reg;
        next_exec[CB_LO_MSB:CB_LO_LSB] = TWO_ZERO;
        next_exec[LOW_MSB:LOW_LSB] = TWO_ZERO;
      end else begin
        next_restart = 1'b1;
      end
    end
    if (xfer_i.resumed && !cb_live(exec_q)) begin
      next_exec[RES_MSB:RES_LSB] = RES_NONE;
    end
    unique case (tbit_i.src)
      SRC_NONE: begin
      end
      SRC_BRANCH_REG, SRC_PC_LOAD, SRC_VECTOR: begin
        next_exec[ISA_BIT] = tbit_i.value[0];
      end
      SRC_EXC_RET: begin
        next_exec = tbit_i.value & EXEC_KEEP;
      end
      default: begin
      end
    endcase
    // reserved bits never leave zero
    next_exec = next_exec & EXEC_KEEP;
  end

  // the state bit is only tracked; no other state exists
  always_comb begin
    next_fault = instr_issue_i && !exec_q[ISA_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      exec_q <= ZERO_WORD;
      restart_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      exec_q <= next_exec;
      restart_q <= next_restart;
      fault_q <= next_fault;
    end
  end

  // without the extension only the secure copy exists
  assign bank_s = sreg_i.secure || !SECURE_EXT;

  always_comb begin
    next_imask_s = imask_s;
    next_imask_ns = imask_ns;
    next_fblock_s = fblock_s;
    next_fblock_ns = fblock_ns;
    next_rdata = ZERO_WORD;
    if (sreg_i.wr) begin
      unique case (sreg_i.sel)
        SEL_EXEC: begin
        end
        SEL_IMASK: begin
          if (bank_s) begin
            next_imask_s = sreg_i.wdata[MASK_BIT];
          end else begin
            next_imask_ns = sreg_i.wdata[MASK_BIT];
          end
        end
        SEL_FMASK: begin
          if (bank_s) begin
            next_fblock_s = sreg_i.wdata[MASK_BIT];
          end else begin
            next_fblock_ns = sreg_i.wdata[MASK_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    // change instr comes after the write so it wins a same-cycle clash
    if (mask_chg_i.valid) begin
      if (mask_chg_i.fault) begin
        if (mask_chg_i.secure || !SECURE_EXT) begin
          next_fblock_s = mask_chg_i.disable_exc;
        end else begin
          next_fblock_ns = mask_chg_i.disable_exc;
        end
      end else if (mask_chg_i.secure || !SECURE_EXT) begin
        next_imask_s = mask_chg_i.disable_exc;
      end else begin
        next_imask_ns = mask_chg_i.disable_exc;
      end
    end
    if (sreg_i.rd) begin
      unique case (sreg_i.sel)
        SEL_EXEC: next_rdata = ZERO_WORD;
        SEL_IMASK: begin
          next_rdata[MASK_BIT] = bank_s ? imask_s : imask_ns;
        end
        SEL_FMASK: begin
          next_rdata[MASK_BIT] = bank_s ? fblock_s : fblock_ns;
        end
        default: next_rdata = ZERO_WORD;
      endcase
    end
  end

  // boost is the most urgent of all active masks
  always_comb begin
    next_prio = PRIO_NONE;
    if (next_imask_s) begin
      next_prio = lower(next_prio, PRIO_ZERO);
    end
    if (next_imask_ns && SECURE_EXT) begin
      next_prio = lower(next_prio,
        priority_split_i ? PRIO_SPLIT : PRIO_ZERO);
    end
    if (next_fblock_s) begin
      next_prio = lower(next_prio, (SECURE_EXT && fault_routing_i) ?
        PRIO_FAULT_S : PRIO_FAULT);
    end
    if (next_fblock_ns && SECURE_EXT) begin
      next_prio = lower(next_prio, fault_routing_i ? PRIO_FAULT :
        (priority_split_i ? PRIO_SPLIT : PRIO_ZERO));
    end
    // signed compare: a smaller number is more urgent
    next_blocked = pend_i.valid && (pend_i.prio >= prio_q);
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      imask_s <= 1'b0;
      imask_ns <= 1'b0;
      fblock_s <= 1'b0;
      fblock_ns <= 1'b0;
      rdata_q <= ZERO_WORD;
      prio_q <= PRIO_NONE;
      blocked_q <= 1'b0;
    end else begin
      imask_s <= next_imask_s;
      imask_ns <= next_imask_ns;
      fblock_s <= next_fblock_s;
      fblock_ns <= next_fblock_ns;
      rdata_q <= next_rdata;
      prio_q <= next_prio;
      blocked_q <= next_blocked;
    end
  end

  assign sreg_rdata_o = rdata_q;
  assign exec_state_o = exec_q;
  assign resume_reg_o = exec_q[RES_MSB:RES_LSB];
  assign resume_valid_o = !cb_live(exec_q) &&
    (exec_q[RES_MSB:RES_LSB] != RES_NONE);
  assign xfer_restart_o = restart_q;
  assign cb_active_o = cb_live(exec_q);
  assign state_fault_o = fault_q;
  assign exec_prio_o = prio_q;
  assign pend_blocked_o = blocked_q;

  default clocking cb_clk @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  reserved_zero_a: assert property (
    (exec_state_o & ~EXEC_KEEP) == ZERO_WORD)
    else $error("reserved exec bits set");

  exec_read_zero_a: assert property (
    sreg_i.rd && sreg_i.sel == SEL_EXEC |=> sreg_rdata_o == ZERO_WORD)
    else $error("exec read not zero");

  exec_write_ignored_a: assert property (
    sreg_i.wr && sreg_i.sel == SEL_EXEC && tbit_i.src == SRC_NONE &&
    !cb_i.start && !cb_i.step && !xfer_i.intr && !xfer_i.resumed
    |=> $stable(exec_state_o))
    else $error("exec write took effect");

  suspend_record_a: assert property (
    xfer_i.intr && xfer_i.can_suspend && !cb_active_o &&
    tbit_i.src == SRC_NONE && !cb_i.start && !xfer_i.resumed
    |=> resume_reg_o == $past(xfer_i.next_reg) &&
        exec_state_o[LOW_MSB:LOW_LSB] == TWO_ZERO &&
        exec_state_o[CB_LO_MSB:CB_LO_LSB] == TWO_ZERO)
    else $error("resume point not recorded");

  restart_cond_a: assert property (
    xfer_i.intr && (cb_active_o || !xfer_i.can_suspend)
    |=> xfer_restart_o ##1 !xfer_restart_o || $past(xfer_i.intr))
    else $error("transfer not restarted");

  state_source_a: assert property (
    $changed(exec_state_o[ISA_BIT]) |-> $past(tbit_i.src) != SRC_NONE)
    else $error("state bit changed without source");

  state_fault_a: assert property (
    instr_issue_i && !exec_state_o[ISA_BIT] |=> state_fault_o)
    else $error("no fault on bad state");

  imask_boost_a: assert property (
    sreg_i.wr && sreg_i.sel == SEL_IMASK && sreg_i.wdata[MASK_BIT] &&
    bank_s && !mask_chg_i.valid |=> exec_prio_o <= PRIO_ZERO)
    else $error("interrupt mask did not boost");

  fault_boost_a: assert property (
    SECURE_EXT && fault_routing_i && mask_chg_i.valid && mask_chg_i.fault &&
    mask_chg_i.secure && mask_chg_i.disable_exc
    |=> exec_prio_o == PRIO_FAULT_S)
    else $error("secure fault boost wrong");

  blocked_cmp_a: assert property (
    ##1 pend_blocked_o == ($past(pend_i.valid) &&
      ($past(pend_i.prio) >= $past(exec_prio_o))))
    else $error("masking compare wrong");

endmodule

/* pkg/exec_mask_pkg.sv */
package exec_mask_pkg;
  localparam int ISA_BIT = 24;
  localparam int CB_HI_MSB = 15;
  localparam int CB_HI_LSB = 10;
  localparam int CB_LO_MSB = 26;
  localparam int CB_LO_LSB = 25;
  localparam int RES_MSB = 15;
  localparam int RES_LSB = 12;
  localparam int LOW_MSB = 11;
  localparam int LOW_LSB = 10;
  localparam int CB_TAIL_MSB = 4;
  localparam int CB_BASE_MSB = 7;
  localparam int CB_BASE_LSB = 5;
  localparam int CB_END_MSB = 2;
  localparam int MASK_BIT = 0;
  localparam logic [31:0] EXEC_KEEP = 32'h0700_FC00;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [7:0] CB_IDLE = 8'h00;
  localparam logic [3:0] RES_NONE = 4'h0;
  localparam logic [1:0] TWO_ZERO = 2'h0;
  localparam logic [2:0] THREE_ZERO = 3'h0;

  typedef logic signed [9:0] prio_t;
  localparam prio_t PRIO_NONE = 10'sh100;
  localparam prio_t PRIO_ZERO = 10'sh000;
  localparam prio_t PRIO_SPLIT = 10'sh080;
  localparam prio_t PRIO_FAULT = -10'sh001;
  localparam prio_t PRIO_FAULT_S = -10'sh003;

  typedef enum logic [1:0] {
    SEL_EXEC = 2'b00,
    SEL_IMASK = 2'b01,
    SEL_FMASK = 2'b10
  } sreg_sel_e;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_BRANCH_REG = 3'b001,
    SRC_PC_LOAD = 3'b010,
    SRC_EXC_RET = 3'b011,
    SRC_VECTOR = 3'b100
  } tbit_src_e;

  typedef struct packed {
    logic rd;
    logic wr;
    sreg_sel_e sel;
    logic secure;
    logic [31:0] wdata;
  } sreg_req_s;

  typedef struct packed {
    logic valid;
    logic fault;
    logic secure;
    logic disable_exc;
  } mask_chg_req_s;

  typedef struct packed {
    tbit_src_e src;
    logic [31:0] value;
  } tbit_upd_s;

  typedef struct packed {
    logic intr;
    logic can_suspend;
    logic [3:0] next_reg;
    logic resumed;
  } xfer_req_s;

  typedef struct packed {
    logic start;
    logic [7:0] state;
    logic step;
  } cb_req_s;

  typedef struct packed {
    logic valid;
    prio_t prio;
  } pend_req_s;
endpackage

/* verif/testbench.sv */
module testbench
  import exec_mask_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    int sig;
    logic [31:0] val;
  } note_s;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  sreg_req_s sreg, next_sreg;
  mask_chg_req_s mask_chg, next_mask_chg;
  tbit_upd_s tbit, next_tbit;
  xfer_req_s xfer, next_xfer;
  cb_req_s cb, next_cb;
  pend_req_s pend, next_pend;
  logic issue, split, routing, next_issue;
  logic [31:0] sreg_rdata_o, exec_state_o;
  logic resume_valid_o, xfer_restart_o, cb_active_o;
  logic state_fault_o, pend_blocked_o;
  logic [3:0] resume_reg_o;
  prio_t exec_prio_o;
  note_s notes[$];
  note_s n;
  int errors = 0;
  int num_checks = 0;
  int seed = 32'hD8D865D6;
  logic [31:0] word;
  logic [7:0] st;
  logic [3:0] nr;
  prio_t boost;
  string names [9] = '{"rdata", "exec_state", "resume_valid", "resume_reg",
    "restart", "cb_active", "state_fault", "exec_prio", "pend_blocked"};

  always #5 clk_i = ~clk_i;

  exec_state_mask #(.SECURE_EXT(1'b1)) uut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .sreg_i(sreg),
    .mask_chg_i(mask_chg),
    .tbit_i(tbit),
    .xfer_i(xfer),
    .cb_i(cb),
    .pend_i(pend),
    .instr_issue_i(issue),
    .priority_split_i(split),
    .fault_routing_i(routing),
    .sreg_rdata_o(sreg_rdata_o),
    .exec_state_o(exec_state_o),
    .resume_valid_o(resume_valid_o),
    .resume_reg_o(resume_reg_o),
    .xfer_restart_o(xfer_restart_o),
    .cb_active_o(cb_active_o),
    .state_fault_o(state_fault_o),
    .exec_prio_o(exec_prio_o),
    .pend_blocked_o(pend_blocked_o)
  );

  function automatic logic [31:0] seen(int s);
    case (s)
      0: return sreg_rdata_o;
      1: return exec_state_o;
      2: return {31'h0, resume_valid_o};
      3: return {28'h0, resume_reg_o};
      4: return {31'h0, xfer_restart_o};
      5: return {31'h0, cb_active_o};
      6: return {31'h0, state_fault_o};
      7: return {{22{exec_prio_o[9]}}, exec_prio_o};
      default: return {31'h0, pend_blocked_o};
    endcase
  endfunction

  function automatic logic [31:0] ext(prio_t p);
    return {{22{p[9]}}, p};
  endfunction

  // state bit assumed set while a block runs
  function automatic logic [31:0] cbw(logic [7:0] s);
    return {5'h0, s[1:0], 1'b1, 8'h0, s[7:2], 10'h0};
  endfunction

  task automatic note(int s, logic [31:0] v);
    notes.push_back('{s, v});
  endtask

  // staged copies land once per falling edge, so no pin moves twice
  task automatic cyc();
    @(negedge clk_i);
    sreg = next_sreg;
    mask_chg = next_mask_chg;
    tbit = next_tbit;
    xfer = next_xfer;
    cb = next_cb;
    pend = next_pend;
    issue = next_issue;
    next_sreg = '0;
    next_mask_chg = '0;
    next_tbit = '0;
    next_xfer = '0;
    next_cb = '0;
    next_pend = '0;
    next_issue = 1'b0;
  endtask

  task automatic sreg_op(logic w, sreg_sel_e s, logic sec, logic [31:0] d);
    next_sreg = '{!w, w, s, sec, d};
    cyc();
  endtask

  task automatic rd(sreg_sel_e s, logic sec, logic [31:0] e);
    sreg_op(1'b0, s, sec, 32'h0);
    note(0, e);
  endtask

  task automatic set_mask(logic f, logic sec, logic v, logic c, prio_t e);
    word = $random(seed);
    if (c) begin
      next_mask_chg = '{1'b1, f, sec, v};
      cyc();
    end else begin
      sreg_op(1'b1, f ? SEL_FMASK : SEL_IMASK, sec, {word[31:1], v});
    end
    note(7, ext(e));
  endtask

  task automatic probe(prio_t p, logic e);
    next_pend = '{1'b1, p};
    cyc();
    note(8, {31'h0, e});
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // the delay lets this edge's register updates land before sampling
  always @(posedge clk_i) begin
    #1;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      num_checks++;
      if (seen(n.sig) !== n.val) begin
        errors++;
        $display("Error %s expected %h seen %h", names[n.sig], n.val,
          seen(n.sig));
      end
    end
  end

  initial begin
    {sreg, mask_chg, tbit, xfer, cb, pend, issue, split, routing} = '0;
    {next_sreg, next_mask_chg, next_tbit, next_xfer, next_cb, next_pend,
      next_issue} = '0;
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    note(7, ext(PRIO_NONE));
    note(1, 32'h0);
    next_issue = 1'b1;
    cyc();
    note(6, 32'h1);
    word = $random(seed);
    next_tbit = '{SRC_VECTOR, word | 32'h1};
    cyc();
    note(1, 32'h0100_0000);
    next_issue = 1'b1;
    next_tbit = '{tbit_src_e'(3'h5), 32'h0};
    cyc();
    note(1, 32'h0100_0000);
    note(6, 32'h0);
    sreg_op(1'b1, SEL_EXEC, 1'b0, word);
    note(1, 32'h0100_0000);
    rd(SEL_EXEC, 1'b0, 32'h0);
    rd(sreg_sel_e'(2'b11), 1'b0, 32'h0);
    for (int r = 0; r < 2; r++) begin
      for (int s = 0; s < 2; s++) begin
        cyc();
        split = s[0];
        routing = r[0];
        boost = s[0] ? PRIO_SPLIT : PRIO_ZERO;
        set_mask(1'b0, 1'b0, 1'b1, r[0], boost);
        rd(SEL_IMASK, 1'b0, 32'h1);
        probe(boost, 1'b1);
        probe(prio_t'(boost - 1), 1'b0);
        set_mask(1'b1, 1'b0, 1'b1, s[0], r ? PRIO_FAULT : boost);
        set_mask(1'b1, 1'b1, 1'b1, s[0], r ? PRIO_FAULT_S : PRIO_FAULT);
        probe(PRIO_FAULT, 1'b1);
        rd(SEL_FMASK, 1'b1, 32'h1);
        set_mask(1'b1, 1'b1, 1'b0, s[0], r ? PRIO_FAULT : boost);
        set_mask(1'b1, 1'b0, 1'b0, s[0], boost);
        set_mask(1'b0, 1'b1, 1'b1, r[0], PRIO_ZERO);
        set_mask(1'b0, 1'b0, 1'b0, r[0], PRIO_ZERO);
        set_mask(1'b0, 1'b1, 1'b0, r[0], PRIO_NONE);
      end
    end
    st = 8'hA1;
    next_cb = '{1'b1, st, 1'b0};
    cyc();
    note(1, cbw(st));
    for (int i = 0; i < 4; i++) begin
      next_cb.step = 1'b1;
      next_xfer = '{i == 0, 1'b1, 4'h3, 1'b0};
      cyc();
      st = (i == 3) ? 8'h00 : {st[7:5], st[3:0], 1'b0};
      note(1, (i == 3) ? 32'h0100_0000 : cbw(st));
      note(5, {31'h0, i < 3});
      note(4, {31'h0, i == 0});
    end
    // register 0 reads as no resume point, so force it nonzero
    nr = word[3:0] | 4'h1;
    next_xfer = '{1'b1, 1'b1, nr, 1'b0};
    cyc();
    note(3, {28'h0, nr});
    note(2, 32'h1);
    note(1, {16'h0100, nr, 12'h0});
    next_xfer.resumed = 1'b1;
    cyc();
    note(3, 32'h0);
    note(2, 32'h0);
    // restarted transfers here only touch memory that tolerates repeats
    next_xfer = '{1'b1, 1'b0, nr, 1'b0};
    cyc();
    note(4, 32'h1);
    note(1, 32'h0100_0000);
    word = $random(seed);
    next_tbit = '{SRC_EXC_RET, word};
    cyc();
    note(1, word & EXEC_KEEP);
    rd(SEL_EXEC, 1'b1, 32'h0);
    next_tbit = '{SRC_BRANCH_REG, 32'hFFFF_FFFE};
    cyc();
    note(1, word & EXEC_KEEP & 32'hFEFF_FFFF);
    next_issue = 1'b1;
    cyc();
    note(6, 32'h1);
    next_tbit = '{SRC_PC_LOAD, 32'h1};
    cyc();
    note(1, (word & EXEC_KEEP) | 32'h0100_0000);
    for (int i = 0; i < 10 && notes.size() > 0; i++) @(negedge clk_i);
    if (notes.size() > 0) errors++;
    summarize();
  end
endmodule
